/* design/msc_top.sv */
// Monitor select, strap decode and line path control with an APB register slave.
//
// The APB interface to the registers and the address map were left to the implementer.
`timescale 1ns/100ps
module msc_top
  import msc_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [3:0] monitor_select,
  input wire logic top_address_pin,
  input wire logic [4:0] host_address_bus,
  input wire logic bus_multiplex_select,
  input wire logic line_drive_enable,
  input wire logic clock_edge_choice,
  input wire logic host_mode,
  input wire msc_line_t rx_line,
  input wire msc_line_t tx_data,
  output msc_line_t tx_line,
  output logic [MSC_NCH-1:0] tx_line_oe_n,
  output logic [MSC_NCH-1:0] recv_data_positive,
  output logic [MSC_NCH-1:0] recv_data_negative,
  output logic rx0_route_tip,
  output logic rx0_route_ring,
  output logic monitor_active
);

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    logic ctrl_rlb;
    logic [3:0] ctrl_msel;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    msc_line_t tx;
    logic [MSC_NCH-1:0] oe_n;
    logic [MSC_NCH-1:0] rdp;
    logic [MSC_NCH-1:0] rdn;
    logic rx0_tip;
    logic rx0_ring;
    logic mon_active;
    logic [3:0] mon_code;
    logic [4:0] haddr;
    logic addr_fault;
    logic top_fault;
    logic past_ok;
  } msc_state_t;

  msc_state_t st_r;
  msc_state_t st_nxt;
  msc_pins_t pins_raw;
  msc_pins_t sp;
  logic [3:0] code_now;
  logic route_tip;
  logic route_ring;
  logic route_active;
  logic rd_inv;
  logic acc;
  logic [31:0] stat_word;

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  always_comb begin
    pins_raw.monitor_select = monitor_select;
    pins_raw.top_address_pin = top_address_pin;
    pins_raw.host_address_bus = host_address_bus;
    pins_raw.bus_multiplex_select = bus_multiplex_select;
    pins_raw.line_drive_enable = line_drive_enable;
    pins_raw.clock_edge_choice = clock_edge_choice;
    pins_raw.host_mode = host_mode;
    pins_raw.rx = rx_line;
  end

  msc_sync #(.W($bits(msc_pins_t))) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .d(pins_raw),
    .q(sp)
  );

  // ****************************************************************
  // Monitor selection and routing
  // ****************************************************************
  // Host mode takes the selection from the control register, hardware mode from the pins.
  always_comb begin
    code_now = sp.host_mode ? st_r.ctrl_msel : sp.monitor_select;
  end

  msc_route u_route (
    .code(code_now),
    .tx(st_r.tx),
    .rx(sp.rx),
    .tip(route_tip),
    .ring(route_ring),
    .active(route_active)
  );

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    st_nxt = st_r;
    st_nxt.past_ok = 1'b1;
    rd_inv = ~sp.clock_edge_choice;
    acc = psel & penable & st_r.pready;
    stat_word = MSC_WORD_ZERO;
    stat_word[MSC_STAT_CODE_LSB +: 4] = st_r.mon_code;
    stat_word[MSC_STAT_ACTIVE_BIT] = st_r.mon_active;
    stat_word[MSC_STAT_TXSEL_BIT] = st_r.mon_active & st_r.mon_code[3];
    stat_word[MSC_STAT_TOPFLT_BIT] = st_r.top_fault;
    stat_word[MSC_STAT_HIZ_BIT] = &st_r.oe_n;
    stat_word[MSC_STAT_EDGE_BIT] = sp.clock_edge_choice;
    stat_word[MSC_STAT_HOST_BIT] = sp.host_mode;
    stat_word[MSC_STAT_ADDR_LSB +: 5] = st_r.haddr;
    stat_word[MSC_STAT_ADRFLT_BIT] = st_r.addr_fault;

    // APB slave: one wait-free access phase after setup.
    st_nxt.pready = psel & ~penable;
    st_nxt.pslverr = 1'b0;
    st_nxt.prdata = MSC_WORD_ZERO;
    if (psel & ~penable) begin
      if (paddr == MSC_CTRL_OFS) begin
        st_nxt.prdata[MSC_CTRL_RLB_BIT] = st_r.ctrl_rlb;
        st_nxt.prdata[MSC_CTRL_MSEL_LSB +: 4] = st_r.ctrl_msel;
      end else if (paddr == MSC_STAT_OFS) begin
        st_nxt.prdata = stat_word;
      end else begin
        st_nxt.pslverr = 1'b1;
      end
    end
    if (acc & pwrite & (paddr == MSC_CTRL_OFS)) begin
      st_nxt.ctrl_rlb = pwdata[MSC_CTRL_RLB_BIT];
      st_nxt.ctrl_msel = pwdata[MSC_CTRL_MSEL_LSB +: 4];
    end

    // Monitoring path into channel 0's receiver.
    st_nxt.mon_code = code_now;
    st_nxt.mon_active = route_active;
    st_nxt.rx0_tip = route_tip;
    st_nxt.rx0_ring = route_ring;
    st_nxt.top_fault = ~sp.host_mode & sp.top_address_pin;

    // Each receiver slices its own line; channel 0 slices the routed pair.
    st_nxt.rdp = sp.rx.tip ^ {MSC_NCH{rd_inv}};
    st_nxt.rdn = sp.rx.ring ^ {MSC_NCH{rd_inv}};
    st_nxt.rdp[0] = route_tip ^ rd_inv;
    st_nxt.rdn[0] = route_ring ^ rd_inv;

    // Drivers: channels 1 to 7 always carry their own data.
    st_nxt.tx = tx_data;
    if (sp.host_mode & st_r.ctrl_rlb) begin
      st_nxt.tx.tip[0] = st_r.rx0_tip;
      st_nxt.tx.ring[0] = st_r.rx0_ring;
    end
    st_nxt.oe_n = {MSC_NCH{~sp.line_drive_enable}};

    // Address strap capture for the non-multiplexed parallel port.
    if (sp.host_mode & ~sp.bus_multiplex_select) begin
      st_nxt.haddr = sp.host_address_bus;
      st_nxt.addr_fault = 1'b0;
    end else begin
      st_nxt.haddr = st_r.haddr;
      st_nxt.addr_fault = (sp.host_address_bus != 5'h00);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= '0;
      st_r.ctrl_rlb <= MSC_RLB_RST;
      st_r.ctrl_msel <= MSC_MSEL_RST;
      st_r.oe_n <= MSC_OE_N_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign prdata = st_r.prdata;
  assign pready = st_r.pready;
  assign pslverr = st_r.pslverr;
  assign tx_line = st_r.tx;
  assign tx_line_oe_n = st_r.oe_n;
  assign recv_data_positive = st_r.rdp;
  assign recv_data_negative = st_r.rdn;
  assign rx0_route_tip = st_r.rx0_tip;
  assign rx0_route_ring = st_r.rx0_ring;
  assign monitor_active = st_r.mon_active;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sel_source_a: assert property (
      st_r.past_ok |->
      st_r.mon_code == ($past(sp.host_mode) ? $past(st_r.ctrl_msel) : $past(sp.monitor_select)))
    else $error("monitor code not taken from the selected source");

  single_watch_a: assert property (
      st_r.past_ok |->
      monitor_active == ($past(code_now[2:0]) != MSC_SEL_NONE))
    else $error("monitoring state does not follow the select code");

  rx_route_a: assert property (
      st_r.past_ok && $past(code_now == 4'h3) |->
      rx0_route_tip == $past(sp.rx.tip[3]) && rx0_route_ring == $past(sp.rx.ring[3]))
    else $error("receiver 3 not routed to channel 0");

  rx_route_last_a: assert property (
      st_r.past_ok && $past(code_now == 4'h7) |->
      rx0_route_tip == $past(sp.rx.tip[7]) && rx0_route_ring == $past(sp.rx.ring[7]))
    else $error("receiver 7 not routed to channel 0");

  tx_route_a: assert property (
      st_r.past_ok && $past(code_now == 4'hD) |->
      rx0_route_tip == $past(st_r.tx.tip[5]) && rx0_route_ring == $past(st_r.tx.ring[5]))
    else $error("transmitter 5 not routed to channel 0");

  tx_route_first_a: assert property (
      st_r.past_ok && $past(code_now == 4'h9) |->
      rx0_route_tip == $past(st_r.tx.tip[1]) && rx0_route_ring == $past(st_r.tx.ring[1]))
    else $error("transmitter 1 not routed to channel 0");

  no_monitor_a: assert property (
      st_r.past_ok && $past(code_now[2:0] == 3'h0) |->
      !monitor_active && rx0_route_tip == $past(sp.rx.tip[0]))
    else $error("monitoring active with a null code");

  null_tx_code_a: assert property (
      st_r.past_ok && $past(code_now == 4'h8) |->
      !monitor_active && rx0_route_ring == $past(sp.rx.ring[0]))
    else $error("transmitter null code starts monitoring");

  tx_pair_a: assert property (
      st_r.past_ok && $past(code_now == 4'hE) |->
      rx0_route_tip == $past(st_r.tx.tip[6]) && rx0_route_ring == $past(st_r.tx.ring[6]))
    else $error("transmitter 6 line pair not fed to channel 0");

  rx_pair_a: assert property (
      st_r.past_ok && $past(code_now == 4'h1) |->
      rx0_route_tip == $past(sp.rx.tip[1]) && rx0_route_ring == $past(sp.rx.ring[1]))
    else $error("receiver 1 line pair not fed to channel 0");

  ch0_data_a: assert property (
      st_r.past_ok |->
      recv_data_positive[0] == (rx0_route_tip ^ ~$past(sp.clock_edge_choice)))
    else $error("channel 0 data does not follow the routed line");

  ch0_neg_data_a: assert property (
      st_r.past_ok |->
      recv_data_negative[0] == (rx0_route_ring ^ ~$past(sp.clock_edge_choice)))
    else $error("channel 0 negative data does not follow the routed line");

  remote_loopback_a: assert property (
      (sp.host_mode && st_r.ctrl_rlb) |=>
      tx_line.tip[0] == $past(rx0_route_tip) && tx_line.ring[0] == $past(rx0_route_ring))
    else $error("remote loopback not driving channel 0");

  no_loopback_a: assert property (
      !(sp.host_mode && st_r.ctrl_rlb) |=>
      tx_line.tip[0] == $past(tx_data.tip[0]) && tx_line.ring[0] == $past(tx_data.ring[0]))
    else $error("channel 0 driver left its own data without loopback");

  addr_capture_a: assert property (
      (sp.host_mode && !sp.bus_multiplex_select) |=>
      st_r.haddr == $past(sp.host_address_bus))
    else $error("address pins not captured");

  addr_hold_a: assert property (
      !(sp.host_mode && !sp.bus_multiplex_select) |=>
      $stable(st_r.haddr))
    else $error("address capture changed outside the separate bus mode");

  driver_hiz_a: assert property (
      !sp.line_drive_enable [*2] |->
      &tx_line_oe_n ##1
      recv_data_positive[2] == ($past(sp.rx.tip[2]) ^ ~$past(sp.clock_edge_choice)))
    else $error("drivers not high impedance or receivers stopped");

  driver_on_a: assert property (
      sp.line_drive_enable |=>
      !(|tx_line_oe_n))
    else $error("drivers not enabled while the enable pin is high");

  edge_level_a: assert property (
      $changed(sp.clock_edge_choice) && $stable(sp.rx.tip[4]) |=>
      $changed(recv_data_positive[4]))
    else $error("clock edge choice does not flip data level");

  other_chan_a: assert property (
      $changed(code_now) |=>
      tx_line.tip[6] == $past(tx_data.tip[6]) &&
      recv_data_negative[1] == ($past(sp.rx.ring[1]) ^ ~$past(sp.clock_edge_choice)))
    else $error("unselected channel disturbed by selection change");

  apb_ready_a: assert property (
      (psel && !penable) |=> pready)
    else $error("no ready in the first access cycle");

  apb_ready_low_a: assert property (
      !(psel && !penable) |=> !pready)
    else $error("ready raised without a setup cycle");

  apb_error_a: assert property (
      (psel && !penable && paddr != MSC_CTRL_OFS && paddr != MSC_STAT_OFS) |=>
      pslverr && prdata == MSC_WORD_ZERO)
    else $error("unmapped address not answered with an error");

  ctrl_write_a: assert property (
      (psel && penable && pready && pwrite && paddr == MSC_CTRL_OFS) |=>
      st_r.ctrl_msel == $past(pwdata[MSC_CTRL_MSEL_LSB +: 4]) &&
      st_r.ctrl_rlb == $past(pwdata[MSC_CTRL_RLB_BIT]))
    else $error("control write did not land");

  cov_rx_c: cover property (monitor_active && !st_r.mon_code[3]);
  cov_tx_c: cover property (monitor_active && st_r.mon_code[3]);
  cov_lb_c: cover property (sp.host_mode && st_r.ctrl_rlb && monitor_active);
  cov_hiz_c: cover property (&tx_line_oe_n ##1 !(&tx_line_oe_n));
  cov_err_c: cover property (pready && pslverr);

endmodule // msc_top

/* design/msc_pkg.sv */
// Package of constants and carrier types for the monitor select and strap control block.
package msc_pkg;

  // ****************************************************************
  // Sizes, register offsets and field positions
  // ****************************************************************
  localparam int MSC_NCH = 8;
  localparam logic [7:0] MSC_CTRL_OFS = 8'h00;
  localparam logic [7:0] MSC_STAT_OFS = 8'h04;
  localparam int MSC_CTRL_RLB_BIT = 0;
  localparam int MSC_CTRL_MSEL_LSB = 1;
  localparam int MSC_STAT_CODE_LSB = 0;
  localparam int MSC_STAT_ACTIVE_BIT = 4;
  localparam int MSC_STAT_TXSEL_BIT = 5;
  localparam int MSC_STAT_TOPFLT_BIT = 6;
  localparam int MSC_STAT_HIZ_BIT = 7;
  localparam int MSC_STAT_EDGE_BIT = 8;
  localparam int MSC_STAT_HOST_BIT = 9;
  localparam int MSC_STAT_ADDR_LSB = 16;
  localparam int MSC_STAT_ADRFLT_BIT = 21;

  // ****************************************************************
  // Reset values and codes
  // ****************************************************************
  localparam logic MSC_RLB_RST = 1'b0;
  localparam logic [3:0] MSC_MSEL_RST = 4'h0;
  localparam logic [2:0] MSC_SEL_NONE = 3'h0;
  localparam logic [31:0] MSC_WORD_ZERO = 32'h0000_0000;
  localparam logic [7:0] MSC_OE_N_RST = 8'hFF;
  localparam int MSC_SYNC_STAGES = 2;

  // ****************************************************************
  // Carrier types
  // ****************************************************************
  typedef struct packed {
    logic [MSC_NCH-1:0] tip;
    logic [MSC_NCH-1:0] ring;
  } msc_line_t;

  typedef struct packed {
    logic [3:0] monitor_select;
    logic top_address_pin;
    logic [4:0] host_address_bus;
    logic bus_multiplex_select;
    logic line_drive_enable;
    logic clock_edge_choice;
    logic host_mode;
    msc_line_t rx;
  } msc_pins_t;

endpackage

/* design/msc_sync.sv */
// Two-flop synchroniser for a group of pin levels.
`timescale 1ns/100ps
module msc_sync #(
  parameter int W = 1
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } msc_sync_st_t;

  msc_sync_st_t st_r;
  msc_sync_st_t st_nxt;

  // The first stage is read only by the second stage.
  always_comb begin
    st_nxt.s1 = d;
    st_nxt.s2 = st_r.s1;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign q = st_r.s2;
endmodule // msc_sync

/* design/msc_route.sv */
// Selector that picks the line pair fed to the monitoring receiver.
`timescale 1ns/100ps
module msc_route
  import msc_pkg::*;
(
  input wire logic [3:0] code,
  input wire msc_line_t tx,
  input wire msc_line_t rx,
  output logic tip,
  output logic ring,
  output logic active
);
  logic [2:0] idx;

  always_comb begin
    idx = code[2:0];
    active = (idx != MSC_SEL_NONE);
    if (!active) begin
      tip = rx.tip[0];
      ring = rx.ring[0];
    end else if (code[3]) begin
      tip = tx.tip[idx];
      ring = tx.ring[idx];
    end else begin
      tip = rx.tip[idx];
      ring = rx.ring[idx];
    end
  end
endmodule // msc_route

/* verif/msc_strap_model.sv */
// Board strapping and line partner that drives the pin side of the block.
`timescale 1ns/100ps
module msc_strap_model
  import msc_pkg::*;
(
  input wire logic pclk,
  output logic [3:0] monitor_select,
  output logic top_address_pin,
  output logic [4:0] host_address_bus,
  output logic bus_multiplex_select,
  output logic line_drive_enable,
  output logic clock_edge_choice,
  output logic host_mode,
  output msc_line_t rx_line
);
  initial begin
    monitor_select = 4'h0;
    top_address_pin = 1'b0;
    host_address_bus = 5'h00;
    bus_multiplex_select = 1'b0;
    line_drive_enable = 1'b1;
    clock_edge_choice = 1'b1;
    host_mode = 1'b0;
    rx_line = {8'hA5, 8'h3C};
  end

  // Straps change just after an edge, as a board controller would.
  task automatic set_pins(input logic host, input logic [3:0] code, input logic mux,
                          input logic [4:0] addr, input logic oe, input logic edge_hi);
    @(posedge pclk);
    host_mode <= host;
    monitor_select <= code;
    top_address_pin <= 1'b0;
    bus_multiplex_select <= mux;
    host_address_bus <= mux ? 5'h00 : addr;
    line_drive_enable <= oe;
    clock_edge_choice <= edge_hi;
  endtask
endmodule // msc_strap_model

/* verif/monitor_select_and_strap_control_tb.sv */
// Self-checking testbench of the monitor select and strap control block.
`timescale 1ns/100ps
module monitor_select_and_strap_control_tb;
  import msc_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [3:0] monitor_select;
  logic top_address_pin;
  logic [4:0] host_address_bus;
  logic bus_multiplex_select;
  logic line_drive_enable;
  logic clock_edge_choice;
  logic host_mode;
  msc_line_t rx_line;
  msc_line_t tx_data = {8'h5A, 8'hC3};
  msc_line_t tx_line;
  logic [7:0] tx_line_oe_n;
  logic [7:0] recv_data_positive;
  logic [7:0] recv_data_negative;
  logic rx0_route_tip;
  logic rx0_route_ring;
  logic monitor_active;
  int miscompares = 0;
  int n_checks = 0;
  int cycles = 0;

  always #5 pclk = ~pclk;

  msc_strap_model strap_u (.pclk(pclk), .monitor_select(monitor_select),
    .top_address_pin(top_address_pin), .host_address_bus(host_address_bus),
    .bus_multiplex_select(bus_multiplex_select), .line_drive_enable(line_drive_enable),
    .clock_edge_choice(clock_edge_choice), .host_mode(host_mode), .rx_line(rx_line));

  msc_top dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .monitor_select(monitor_select), .top_address_pin(top_address_pin),
    .host_address_bus(host_address_bus), .bus_multiplex_select(bus_multiplex_select),
    .line_drive_enable(line_drive_enable), .clock_edge_choice(clock_edge_choice),
    .host_mode(host_mode), .rx_line(rx_line), .tx_data(tx_data), .tx_line(tx_line),
    .tx_line_oe_n(tx_line_oe_n), .recv_data_positive(recv_data_positive),
    .recv_data_negative(recv_data_negative), .rx0_route_tip(rx0_route_tip),
    .rx0_route_ring(rx0_route_ring), .monitor_active(monitor_active));

  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  task automatic wrap_up();
    $display("checks=%0d miscompares=%0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic hw_sweep();
    logic [2:0] ch;
    logic act;
    logic et;
    logic er;
    for (int i = 0; i < 16; i++) begin
      ch = i[2:0];
      act = (ch != 3'h0);
      strap_u.set_pins(1'b0, i[3:0], 1'b0, 5'h00, 1'b1, 1'b1);
      repeat (8) @(posedge pclk);
      et = !act ? rx_line.tip[0] : i[3] ? tx_data.tip[ch] : rx_line.tip[ch];
      er = !act ? rx_line.ring[0] : i[3] ? tx_data.ring[ch] : rx_line.ring[ch];
      chk({31'h0, monitor_active}, {31'h0, act});
      chk({30'h0, rx0_route_tip, rx0_route_ring}, {30'h0, et, er});
      chk({30'h0, recv_data_positive[0], recv_data_negative[0]}, {30'h0, et, er});
      chk({18'h0, recv_data_positive[7:1], recv_data_negative[7:1]},
          {18'h0, rx_line.tip[7:1], rx_line.ring[7:1]});
      chk({8'h0, tx_line_oe_n, tx_line}, {8'h0, 8'h00, tx_data});
    end
  endtask

  task automatic hiz_and_edge();
    strap_u.set_pins(1'b0, 4'h2, 1'b0, 5'h00, 1'b0, 1'b0);
    repeat (8) @(posedge pclk);
    chk({24'h0, tx_line_oe_n}, {24'h0, 8'hFF});
    chk({30'h0, monitor_active, rx0_route_tip}, {30'h0, 1'b1, rx_line.tip[2]});
    chk({29'h0, recv_data_positive[0], recv_data_negative[0], recv_data_positive[5]},
        {29'h0, ~rx_line.tip[2], ~rx_line.ring[2], ~rx_line.tip[5]});
  endtask

  task automatic host_loopback();
    logic [31:0] r;
    logic e;
    strap_u.set_pins(1'b1, 4'h0, 1'b0, 5'h15, 1'b1, 1'b1);
    repeat (8) @(posedge pclk);
    apb(1'b1, MSC_CTRL_OFS, 32'h0000_0017, r, e);
    repeat (8) @(posedge pclk);
    chk({30'h0, rx0_route_tip, rx0_route_ring}, {30'h0, tx_data.tip[3], tx_data.ring[3]});
    chk({30'h0, tx_line.tip[0], tx_line.ring[0]}, {30'h0, tx_data.tip[3], tx_data.ring[3]});
    apb(1'b0, MSC_CTRL_OFS, 32'h0, r, e);
    chk(r, 32'h0000_0017);
    apb(1'b0, MSC_STAT_OFS, 32'h0, r, e);
    chk(r & 32'h003F_03FF, 32'h0015_033B);
    apb(1'b0, 8'h08, 32'h0, r, e);
    chk({31'h0, e}, 32'h0000_0001);
    chk(r, 32'h0000_0000);
    strap_u.set_pins(1'b1, 4'h0, 1'b1, 5'h0A, 1'b1, 1'b1);
    repeat (8) @(posedge pclk);
    apb(1'b0, MSC_STAT_OFS, 32'h0, r, e);
    chk(r & 32'h003F_0000, 32'h0015_0000);
  endtask

  always @(posedge pclk) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      wrap_up();
    end
  end

  initial begin
    repeat (6) @(posedge pclk);
    chk({23'h0, tx_line_oe_n, monitor_active}, {23'h0, 8'hFF, 1'b0});
    presetn <= 1'b1;
    hw_sweep();
    hiz_and_edge();
    host_loopback();
    wrap_up();
  end
endmodule // monitor_select_and_strap_control_tb
